// ===== rtl/sfc_map.svh
// sfc_map.svh: opcodes, status fields, lock bases and timing for the flash command block
// assumes: included by the design file and the bench, definitions only
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
// opcodes; the masked ones ignore bit 3
`define SFC_OPC_MASK 8'hF7
`define SFC_OP_LSET 8'h06
`define SFC_OP_LCLR 8'h04
`define SFC_OP_SRD 8'h05
`define SFC_OP_SWR 8'h01
`define SFC_OP_PROG 8'h02
`define SFC_OP_READ 8'h03
`define SFC_OP_FREAD 8'h0B
`define SFC_OP_SECT_A 8'h20
`define SFC_OP_SECT_B 8'hD7
`define SFC_OP_BLK_A 8'h52
`define SFC_OP_BLK_B 8'hD8
`define SFC_OP_CHIP_A 8'h60
`define SFC_OP_CHIP_B 8'hC7
`define SFC_OP_ID_A 8'h9F
`define SFC_OP_ID_B 8'hAB
// device_status_word fields
`define SFC_ST_BUSY 0
`define SFC_ST_WEL 1
`define SFC_ST_BP0 2
`define SFC_ST_BP1 3
`define SFC_ST_BP3 5
`define SFC_ST_BP4 6
`define SFC_ST_PIN_PROTECT_ENABLE 7
`define SFC_ST_NV_MASK 8'hEC
`define SFC_ST_RESET 8'h00
`define SFC_ST_BUSY_WORD 8'hFF
// lowest locked address per level
`define SFC_LOCK_L1 17'h1F000
`define SFC_LOCK_L2 17'h1E000
`define SFC_LOCK_L3 17'h1C000
`define SFC_LOCK_L4 17'h18000
`define SFC_LOCK_L5 17'h10000
`define SFC_LOCK_L6 17'h00000
`define SFC_SECT_SPAN 17'h00FFF
`define SFC_BLK_SPAN 17'h07FFF
`define SFC_PAGE_SPAN 17'h000FF
// byte index that completes each command, the byte count's saturation value and the identity length in bits
`define SFC_BYTE_SWR 3'd1
`define SFC_BYTE_ADDR 3'd3
`define SFC_BYTE_FREAD 3'd4
`define SFC_BYTE_SAT 3'd5
`define SFC_ID_BITS 5'd24
// timing
`define SFC_SYS_CLK_HZ 10000000
`define SFC_SR_WRITE_MS 60
`endif

// ===== rtl/sfc_pkg.sv
// sfc_pkg.sv: types shared by the flash command block
// assumes: sfc_map.svh on the include path
package sfc_pkg;
	typedef enum logic [3:0] {
		CM_NONE = 4'h0, CM_LSET = 4'h1, CM_LCLR = 4'h2, CM_SRD = 4'h3,
		CM_SWR = 4'h4, CM_READ = 4'h5, CM_FREAD = 4'h6, CM_PROG = 4'h7,
		CM_SECT = 4'h8, CM_BLK = 4'h9, CM_CHIP = 4'hA, CM_ID = 4'hB, CM_BAD = 4'hC
	} sfc_cmd_t;
	typedef enum logic [2:0] {
		MD_CMD = 3'h0, MD_ADDR = 3'h1, MD_WDATA = 3'h2, MD_STAT = 3'h3,
		MD_ID = 3'h4, MD_READ = 3'h5, MD_DEAD = 3'h6
	} sfc_mode_t;
endpackage : sfc_pkg

// ===== rtl/sfc_flash_cmd.sv
// sfc_flash_cmd.sv: opcode decoder, status word and write protection of a serial flash
// assumes: spiClk runs only inside frames, mode 0; array datapaths sit outside and
// report the end of program and erase cycles on arrayDone
//
// Functional notes
// - 8-bit opcode first, all bits MSB first
// - program, erases, status write are write commands
// - 0000X110 sets the write-enable latch
// - 0000X100 clears latch regardless of protect pin
// - 0000X101 shifts out status word
// - 0000X001 loads protect levels and pin enable
// - 03 plain read, 0B read with dummy byte
// - 0000X010 is array program
// - 20 or D7 erase one 4k sector
// - 52 or D8 erase one 32k block
// - 60 or C7 erase whole array
// - 9F and AB both read identity
// - latch cleared at power-up; master sets it first
// - while busy only status read is served
// - bit0 busy, bit1 write-enable latch
// - protect bits 2,3,5,6,7 persist; bit4 unused
// - status reads all ones while busy
// - identity: maker, type, capacity bytes
// - sample on rising edge, launch on falling
// - identity repeats until chip select rises
// - levels 4-6 lock top 32k, 64k, all
// - unknown opcode: ignore input, output stays off
// - pin protect needs pin low and enable set
// - latch clears when status write or program ends
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.svh"

module sfc_flash_cmd
	import sfc_pkg::*;
#(
	parameter int unsigned SR_CYCLES = `SFC_SR_WRITE_MS * (`SFC_SYS_CLK_HZ / 1000),
	parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
	parameter logic [7:0] TYPE_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] SIZE_ID = 8'h3C // arbitrary value
) (
	input wire logic sys_clk, // system clock
	input wire logic rst, // reset, high; sync in the system domain, async on the request record
	input wire logic spiClk, // serial clock from master
	input wire logic csN, // chip select, low active
	input wire logic si, // serial data in
	input wire logic wpN, // write protect pin, low active
	input wire logic arrayDone, // array program or erase finished
	output logic so, // serial data out
	output logic soOeN, // so output enable, low drives
	output logic readGo, // array read may stream
	output logic [16:0] readAddr, // array read start address
	output logic wrStart, // one-cycle start of array cycle
	output sfc_cmd_t wrOp, // program, sector, block or chip
	output logic [16:0] wrAddr, // array write address
	output logic [7:0] statusWord // device_status_word
);
	// the status-write counter is 20 bits wide
	if (SR_CYCLES < 1 || SR_CYCLES >= (1 << 20)) begin : g_sr_range
		$error("SR_CYCLES out of range");
	end

	function automatic sfc_cmd_t decodeOp(input logic [7:0] op);
		logic [7:0] m;
		m = op & `SFC_OPC_MASK;
		decodeOp = CM_BAD;
		if (m == `SFC_OP_LSET) decodeOp = CM_LSET;
		else if (m == `SFC_OP_LCLR) decodeOp = CM_LCLR;
		else if (m == `SFC_OP_SRD) decodeOp = CM_SRD;
		else if (m == `SFC_OP_SWR) decodeOp = CM_SWR;
		else if (m == `SFC_OP_PROG) decodeOp = CM_PROG;
		else if (op == `SFC_OP_READ) decodeOp = CM_READ;
		else if (op == `SFC_OP_FREAD) decodeOp = CM_FREAD;
		else if (op == `SFC_OP_SECT_A || op == `SFC_OP_SECT_B) decodeOp = CM_SECT;
		else if (op == `SFC_OP_BLK_A || op == `SFC_OP_BLK_B) decodeOp = CM_BLK;
		else if (op == `SFC_OP_CHIP_A || op == `SFC_OP_CHIP_B) decodeOp = CM_CHIP;
		else if (op == `SFC_OP_ID_A || op == `SFC_OP_ID_B) decodeOp = CM_ID;
	endfunction : decodeOp

	////////////////////////////////////////////////////////////////////////
	// link domain: shifting on rising spiClk
	logic [2:0] bitIdx_q;
	logic [2:0] byteCnt_q;
	sfc_mode_t mode_q;
	logic [7:0] sh_q;
	logic [4:0] txCnt_q;
	logic [7:0] statA_q;
	logic [7:0] statB_q;
	sfc_cmd_t cmd_q;
	logic reqValid_q;
	logic seqTgl_q;
	logic [16:0] addr_q;
	logic [7:0] data_q;
	logic readGo_q;
	logic [7:0] inByte;
	logic byteEnd;
	sfc_cmd_t opKind;

	assign inByte = {sh_q[6:0], si};
	assign byteEnd = (bitIdx_q == 3'd7);
	assign opKind = decodeOp(inByte);

	always_ff @(posedge spiClk) begin
		sh_q <= inByte;
	end

	// status crosses as a slow level; it only moves at frame edges or cycle end
	always_ff @(posedge spiClk) begin
		statA_q <= statusWord;
		statB_q <= statA_q;
	end

	// frame counters end with chip select, the frame's own signal
	always_ff @(posedge spiClk or posedge csN) begin
		if (csN) begin
			bitIdx_q <= 3'd0;
			byteCnt_q <= 3'd0;
			mode_q <= MD_CMD;
			readGo_q <= 1'b0;
		end else if (mode_q != MD_DEAD) begin
			bitIdx_q <= bitIdx_q + 3'd1;
			if (byteEnd && byteCnt_q != `SFC_BYTE_SAT) begin
				byteCnt_q <= byteCnt_q + 3'd1;
			end
			if (byteEnd && mode_q == MD_CMD) begin
				if (opKind == CM_BAD) begin
					mode_q <= MD_DEAD;
				end else if (statB_q[`SFC_ST_BUSY] && opKind != CM_SRD) begin
					mode_q <= MD_DEAD;
				end else begin
					unique case (opKind)
						CM_SRD: mode_q <= MD_STAT;
						CM_ID: mode_q <= MD_ID;
						CM_SWR: mode_q <= MD_WDATA;
						CM_READ, CM_FREAD, CM_PROG, CM_SECT, CM_BLK: mode_q <= MD_ADDR;
						default: mode_q <= MD_DEAD;
					endcase
				end
			end else if (byteEnd && mode_q == MD_ADDR) begin
				if ((cmd_q == CM_READ && byteCnt_q == `SFC_BYTE_ADDR) ||
					(cmd_q == CM_FREAD && byteCnt_q == `SFC_BYTE_FREAD)) begin
					mode_q <= MD_READ;
					readGo_q <= 1'b1;
				end
			end
		end
	end

	// request record; survives chip select so the system side can read it
	always_ff @(posedge spiClk or posedge rst) begin
		if (rst) begin
			cmd_q <= CM_NONE;
			reqValid_q <= 1'b0;
			seqTgl_q <= 1'b0;
			addr_q <= 17'h00000;
			data_q <= 8'h00;
		end else if (!csN && mode_q != MD_DEAD) begin
			reqValid_q <= 1'b0;
			if (bitIdx_q == 3'd0 && byteCnt_q == 3'd0) begin
				seqTgl_q <= ~seqTgl_q;
			end
			if (byteEnd && mode_q == MD_CMD) begin
				cmd_q <= opKind;
				reqValid_q <= (opKind == CM_LSET || opKind == CM_LCLR ||
					opKind == CM_CHIP) && !statB_q[`SFC_ST_BUSY];
			end else if (byteEnd && mode_q == MD_WDATA && byteCnt_q == `SFC_BYTE_SWR) begin
				data_q <= inByte;
				reqValid_q <= 1'b1;
			end else if (byteEnd && mode_q == MD_ADDR) begin
				if (byteCnt_q <= `SFC_BYTE_ADDR) begin
					addr_q <= {addr_q[8:0], inByte};
				end
				reqValid_q <= ((cmd_q == CM_SECT || cmd_q == CM_BLK) &&
					byteCnt_q == `SFC_BYTE_ADDR) ||
					(cmd_q == CM_PROG && byteCnt_q > `SFC_BYTE_ADDR);
			end
		end
	end

	always_ff @(posedge spiClk or posedge csN) begin
		if (csN) begin
			txCnt_q <= 5'd0;
		end else if (mode_q == MD_STAT || mode_q == MD_ID) begin
			if (mode_q == MD_ID && txCnt_q == `SFC_ID_BITS - 5'd1) begin
				txCnt_q <= 5'd0;
			end else begin
				txCnt_q <= txCnt_q + 5'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain: so launched on falling spiClk, read request registered on rising spiClk
	logic [23:0] idWord;
	assign idWord = {MAKER_ID, TYPE_ID, SIZE_ID};

	always_ff @(negedge spiClk or posedge csN) begin
		if (csN) begin
			so <= 1'b1;
			soOeN <= 1'b1;
		end else if (mode_q == MD_STAT) begin
			soOeN <= 1'b0;
			so <= statB_q[3'd7 - txCnt_q[2:0]];
		end else if (mode_q == MD_ID) begin
			soOeN <= 1'b0;
			so <= idWord[5'd23 - txCnt_q];
		end else begin
			soOeN <= 1'b1;
			so <= 1'b1;
		end
	end

	always_ff @(posedge spiClk or posedge csN) begin
		if (csN) begin
			readGo <= 1'b0;
			readAddr <= 17'h00000;
		end else begin
			readGo <= readGo_q;
			readAddr <= addr_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// system domain
	logic [2:0] csSync_q;
	logic [1:0] wpSync_q;
	logic [1:0] seqSync_q;
	logic seqSeen_q;
	logic busy_q;
	logic wel_q;
	logic [7:0] nv_q;
	logic [7:0] nvPend_q;
	logic srRun_q;
	logic [19:0] srCnt_q;
	logic csRise;
	logic commit;
	logic pinLock;
	logic [17:0] lockInfo;
	logic [16:0] spanEnd;
	logic targetLocked;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			csSync_q <= 3'b111;
			wpSync_q <= 2'b11;
			seqSync_q <= 2'b00;
		end else begin
			csSync_q <= {csSync_q[1:0], csN};
			wpSync_q <= {wpSync_q[0], wpN};
			seqSync_q <= {seqSync_q[0], seqTgl_q};
		end
	end

	// request fields are quiet once chip select is high and seen two flops later
	assign csRise = csSync_q[1] && !csSync_q[2];
	assign commit = csRise && reqValid_q && (seqSync_q[1] != seqSeen_q) && !busy_q;
	assign pinLock = !wpSync_q[1] && nv_q[`SFC_ST_PIN_PROTECT_ENABLE];

	function automatic logic [17:0] lockOf(input logic [7:0] nv);
		lockOf = {1'b1, `SFC_LOCK_L6};
		unique case ({nv[`SFC_ST_BP1], nv[`SFC_ST_BP0]})
			2'b01: lockOf = {1'b1, `SFC_LOCK_L4};
			2'b10: lockOf = {1'b1, `SFC_LOCK_L5};
			2'b11: lockOf = {1'b1, `SFC_LOCK_L6};
			2'b00: begin
				unique case ({nv[`SFC_ST_BP4], nv[`SFC_ST_BP3]})
					2'b01: lockOf = {1'b1, `SFC_LOCK_L1};
					2'b10: lockOf = {1'b1, `SFC_LOCK_L2};
					2'b11: lockOf = {1'b1, `SFC_LOCK_L3};
					2'b00: lockOf = {1'b0, `SFC_LOCK_L6};
				endcase
			end
		endcase
	endfunction : lockOf

	assign lockInfo = lockOf(nv_q);

	always_comb begin
		spanEnd = addr_q | `SFC_PAGE_SPAN;
		if (cmd_q == CM_SECT) spanEnd = addr_q | `SFC_SECT_SPAN;
		else if (cmd_q == CM_BLK) spanEnd = addr_q | `SFC_BLK_SPAN;
		else if (cmd_q == CM_CHIP) spanEnd = `SFC_BLK_SPAN | `SFC_LOCK_L5 | `SFC_LOCK_L4;
	end

	assign targetLocked = lockInfo[17] && (spanEnd >= lockInfo[16:0]);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			seqSeen_q <= 1'b0;
		end else if (csRise) begin
			seqSeen_q <= seqSync_q[1];
		end
	end

	// commands, latch and busy
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wel_q <= 1'b0;
			busy_q <= 1'b0;
			srRun_q <= 1'b0;
			nvPend_q <= `SFC_ST_RESET;
			wrStart <= 1'b0;
			wrOp <= CM_NONE;
			wrAddr <= 17'h00000;
		end else begin
			wrStart <= 1'b0;
			if (commit) begin
				unique case (cmd_q)
					CM_LSET: wel_q <= 1'b1;
					CM_LCLR: wel_q <= 1'b0;
					CM_SWR: begin
						if (wel_q && !pinLock) begin
							busy_q <= 1'b1;
							srRun_q <= 1'b1;
							nvPend_q <= data_q & `SFC_ST_NV_MASK;
						end
					end
					CM_PROG, CM_SECT, CM_BLK, CM_CHIP: begin
						if (wel_q && !targetLocked) begin
							busy_q <= 1'b1;
							wrStart <= 1'b1;
							wrOp <= cmd_q;
							wrAddr <= addr_q;
						end
					end
					default: begin
					end
				endcase
			end else if (busy_q) begin
				if (srRun_q && srCnt_q == 20'(SR_CYCLES - 1)) begin
					busy_q <= 1'b0;
					srRun_q <= 1'b0;
					wel_q <= 1'b0;
				end else if (!srRun_q && arrayDone && !wrStart) begin
					busy_q <= 1'b0;
					wel_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || !srRun_q) begin
			srCnt_q <= 20'h00000;
		end else begin
			srCnt_q <= srCnt_q + 20'h00001;
		end
	end

	// protect bits land when the self-timed status write ends
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			nv_q <= `SFC_ST_RESET;
		end else if (srRun_q && srCnt_q == 20'(SR_CYCLES - 1)) begin
			nv_q <= nvPend_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			statusWord <= `SFC_ST_RESET;
		end else if (busy_q) begin
			statusWord <= `SFC_ST_BUSY_WORD;
		end else begin
			statusWord <= (nv_q & `SFC_ST_NV_MASK) | {6'h00, wel_q, 1'b0};
		end
	end
endmodule : sfc_flash_cmd
`default_nettype wire

// ===== dv/sfc_flash_cmd_asserts.sv
// sfc_flash_cmd_asserts.sv: port assertions of the flash command block
// assumes: bound to sfc_flash_cmd; csN never moves on a sys_clk edge
`timescale 1ns/10ps
`default_nettype none
module sfc_flash_cmd_asserts
	import sfc_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic rst, // sync reset
	input wire logic spiClk, // link clock
	input wire logic csN, // chip select
	input wire logic si, // serial in
	input wire logic wpN, // protect pin
	input wire logic arrayDone, // array finished
	input wire logic so, // serial out
	input wire logic soOeN, // so enable, low drives
	input wire logic readGo, // read may stream
	input wire logic [16:0] readAddr, // read address
	input wire logic wrStart, // array cycle start
	input wire sfc_cmd_t wrOp, // started cycle kind
	input wire logic [16:0] wrAddr, // started address
	input wire logic [7:0] statusWord // status as read
);
	sfc_cmd_t lastOp_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	always_ff @(posedge sys_clk) begin
		if (rst)
			lastOp_q <= CM_NONE;
		else if (wrStart)
			lastOp_q <= wrOp;
	end
	////////////////////////////////////////////////////////////////////////////
	a_start_busy: assert property (wrStart |=> statusWord == 8'hFF)
		else $error("busy not shown after start");
	a_start_ready: assert property (wrStart |-> statusWord[1:0] == 2'b10)
		else $error("start without latch or while busy");
	a_start_kind: assert property (wrStart |-> wrOp inside {CM_PROG, CM_SECT, CM_BLK, CM_CHIP})
		else $error("start of a non-write kind");
	a_busy_ones: assert property (statusWord[0] |-> statusWord == 8'hFF)
		else $error("busy status not all ones");
	a_bit4_zero: assert property (!statusWord[0] |-> !statusWord[4])
		else $error("unused status bit set");
	// erase completion is left out: the latch there is not pinned down
	a_latch_auto: assert property (($fell(statusWord[0]) && lastOp_q inside {CM_NONE, CM_PROG})
		|-> !statusWord[1])
		else $error("latch kept after cycle");
	a_chip_lock: assert property ((wrStart && wrOp == CM_CHIP)
		|-> statusWord[6:5] == 2'b00 && statusWord[3:2] == 2'b00)
		else $error("chip erase while locked");
	a_quarter_lock: assert property ((wrStart && statusWord[3:2] == 2'b01)
		|-> wrAddr < 17'h18000)
		else $error("write into locked quarter");
	a_all_lock: assert property (wrStart |-> statusWord[3:2] != 2'b11)
		else $error("write with whole array locked");
	a_so_idle: assert property (csN |-> soOeN && so && !readGo)
		else $error("outputs active while deselected");
endmodule : sfc_flash_cmd_asserts
bind sfc_flash_cmd sfc_flash_cmd_asserts sfc_flash_cmd_asserts_inst (.sys_clk, .rst, .spiClk,
	.csN, .si, .wpN, .arrayDone, .so, .soOeN, .readGo, .readAddr, .wrStart, .wrOp, .wrAddr,
	.statusWord);
`default_nettype wire

// ===== dv/sfc_spi_master.sv
// sfc_spi_master.sv: behavioural link master, mode 0, 80 ns period
// assumes: the bench calls xfer one frame at a time
`timescale 1ns/10ps
`default_nettype none
module sfc_spi_master (
	output logic spiClk, // stands low between frames
	output logic csN = 1'b0, // chip select, low active
	output logic si, // data to the device
	input wire logic so, // data from the device
	input wire logic soOeN // low while so is driven
);
	initial begin
		spiClk = 1'b0;
		si = 1'b0;
		// a real rising edge at start clears the link counters
		csN <= 1'b1;
	end
	// nb bytes right-aligned in tx; so is taken at every rising edge
	task automatic xfer(input logic [63:0] tx, input int nb, output logic [63:0] rx,
		output logic oeSeen);
		rx = '0;
		oeSeen = 1'b0;
		csN = 1'b0;
		for (int i = 8 * nb - 1; i >= 0; i--) begin
			si = tx[i];
			#40 spiClk = 1'b1;
			rx = {rx[62:0], so};
			if (soOeN === 1'b0)
				oeSeen = 1'b1;
			#40 spiClk = 1'b0;
		end
		#40 csN = 1'b1;
		// a released line must not look like data
		si = ~si;
		// gap so the system side acts on the frame
		#600;
	endtask : xfer
endmodule : sfc_spi_master
`default_nettype wire

// ===== dv/tb_sfc_flash_cmd.sv
// tb_sfc_flash_cmd.sv: self-checking bench of the flash command block
// assumes: sfc_spi_master drives the link; the bench plays the array side
`timescale 1ns/10ps
`include "sfc_map.svh"
`default_nettype none
module tb_sfc_flash_cmd;
	import sfc_pkg::*;
	localparam logic [7:0] MK = 8'h3B; // arbitrary value
	localparam logic [7:0] TY = 8'h4D; // arbitrary value
	localparam logic [7:0] SZ = 8'h2E; // arbitrary value
	logic sys_clk = 1'b0;
	logic rst = 1'b0;
	logic wpN = 1'b1;
	logic arrayDone = 1'b0;
	logic spiClk, csN, si, so, soOeN, wrStart, oe, readGo, lastGo;
	logic [16:0] readAddr, wrAddr, a, lastAddr;
	logic [7:0] stExp = 8'h00;
	logic [7:0] r;
	logic [63:0] rx;
	sfc_cmd_t wrOp;
	integer fails = 0, testsRun = 0, starts = 0, cyc = 0, seed = 32'h83a0;
	logic [7:0] opc [8] = '{8'h02, 8'h0A, 8'h20, 8'hD7, 8'h52, 8'hD8, 8'h60, 8'hC7};
	sfc_cmd_t kind [8] = '{CM_PROG, CM_PROG, CM_SECT, CM_SECT, CM_BLK, CM_BLK, CM_CHIP, CM_CHIP};
	logic [7:0] lvl [6] = '{8'h20, 8'h40, 8'h60, 8'h04, 8'h08, 8'h0C};
	sfc_spi_master sfc_spi_master_inst (.spiClk, .csN, .si, .so, .soOeN);
	sfc_flash_cmd #(.SR_CYCLES(20), .MAKER_ID(MK), .TYPE_ID(TY), .SIZE_ID(SZ)) sfc_flash_cmd_inst (
		.sys_clk, .rst, .spiClk, .csN, .si, .wpN, .arrayDone, .so, .soOeN, .readGo,
		.readAddr, .wrStart, .wrOp, .wrAddr, .statusWord());
	always #50 sys_clk = ~sys_clk;
	// read request as it stood at the last falling edge of the frame
	always @(negedge spiClk) begin
		lastGo = readGo;
		lastAddr = readAddr;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (wrStart === 1'b1)
			starts++;
		if (cyc == 40000) begin
			fails++;
			stopTest();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic stopTest();
		$display("checks %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stopTest
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic spi(input logic [63:0] tx, input int nb);
		@(negedge sys_clk);
		sfc_spi_master_inst.xfer(tx, nb, rx, oe);
	endtask : spi
	task automatic status_read_cmd();
		spi(64'h0500, 2);
		r = rx[7:0];
	endtask : status_read_cmd
	function automatic logic [17:0] lowBase(input logic [7:0] st);
		if (st[3:2] != 2'b00)
			return st[3] ? (st[2] ? 18'h00000 : 18'h10000) : 18'h18000;
		case (st[6:5])
			2'b01: return 18'h1F000;
			2'b10: return 18'h1E000;
			2'b11: return 18'h1C000;
			default: return 18'h20000;
		endcase
	endfunction : lowBase
	function automatic logic expGo(input sfc_cmd_t k, input logic [16:0] ad, input logic [7:0] st);
		logic [16:0] e;
		if (k == CM_CHIP)
			return lowBase(st) == 18'h20000;
		e = ad | (k == CM_PROG ? 17'hFF : k == CM_SECT ? 17'hFFF : 17'h7FFF);
		return {1'b0, e} < lowBase(st);
	endfunction : expGo
	task automatic wr(input int i, input logic [16:0] ad, input logic [7:0] st);
		int s0;
		int nb;
		logic go;
		logic [63:0] tx;
		s0 = starts;
		go = expGo(kind[i], ad, st);
		nb = kind[i] == CM_PROG ? 5 : kind[i] == CM_CHIP ? 1 : 4;
		tx = {24'h0, opc[i], 7'h0, ad, 8'h5A} >> (8 * (5 - nb));
		spi(64'h06, 1);
		spi(tx, nb);
		chk("start count", s0 + go, starts);
		if (go) begin
			chk("start kind", kind[i], wrOp);
			if (kind[i] == CM_PROG)
				chk("start address", ad, wrAddr);
			spi(tx, nb);
			chk("start while busy", s0 + 1, starts);
			status_read_cmd();
			chk("busy status", 8'hFF, r);
			@(negedge sys_clk) arrayDone = 1'b1;
			@(negedge sys_clk) arrayDone = 1'b0;
			status_read_cmd();
			chk("ready bit", 0, r[0]);
			if (kind[i] == CM_PROG)
				chk("latch after program", 0, r[1]);
		end
	endtask : wr
	task automatic wsr(input logic [7:0] d);
		logic ok;
		ok = wpN || !stExp[7];
		spi(64'h06, 1);
		spi({48'h0, 8'h01, d}, 2);
		if (ok)
			stExp = d & `SFC_ST_NV_MASK;
		r = 8'hFF;
		for (int n = 0; n < 12 && r[0] !== 1'b0; n++)
			status_read_cmd();
		// a poll that straddles the end of the cycle mixes two words
		status_read_cmd();
		chk("status word", ok ? stExp : stExp | 8'h02, r);
	endtask : wsr
	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst <= 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		status_read_cmd();
		chk("status after reset", 8'h00, r);
		chk("status drive", 1, oe);
		spi(64'h0E, 1);
		spi(64'h0D00, 2);
		chk("latch set", 8'h02, rx[7:0]);
		@(negedge sys_clk) wpN = 1'b0;
		spi(64'h0C, 1);
		status_read_cmd();
		chk("latch clear", 8'h00, r);
		@(negedge sys_clk) wpN = 1'b1;
		for (int i = 0; i < 2; i++) begin
			spi({i ? 8'hAB : 8'h9F, 56'h0}, 8);
			chk("identity", {MK, TY, SZ, MK, TY, SZ, MK}, rx[55:0]);
		end
		spi(64'h3A0000, 3);
		chk("bad opcode drive", 0, oe);
		a = 17'($random(seed));
		spi({24'h0, 8'h03, 7'h0, a, 8'h00}, 5);
		chk("read start", 1, lastGo);
		chk("read address", a, lastAddr);
		a = 17'($random(seed));
		spi({24'h0, 8'h0B, 7'h0, a, 8'h00}, 5);
		chk("dummy byte wait", 0, lastGo);
		spi({16'h0, 8'h0B, 7'h0, a, 16'h0}, 6);
		chk("fast read start", 1, lastGo);
		chk("fast read address", a, lastAddr);
		spi({24'h0, 8'h02, 7'h0, a, 8'h11}, 5);
		chk("start without latch", 0, starts);
		for (int i = 0; i < 8; i++)
			wr(i, 17'($random(seed)), 8'h00);
		foreach (lvl[i]) begin
			wsr(lvl[i]);
			a = 17'(lowBase(lvl[i]));
			if (a != 17'h0)
				wr(0, a - 17'h100, lvl[i]);
			wr(0, a, lvl[i]);
			wr(7, 17'h0, lvl[i]);
		end
		wsr(8'h80);
		@(negedge sys_clk) wpN = 1'b0;
		wsr(8'h00);
		@(negedge sys_clk) wpN = 1'b1;
		wsr(8'h00);
		stopTest();
	end
endmodule : tb_sfc_flash_cmd
`default_nettype wire
